// ==== logic/clk_ctrl_pkg.sv ====
// Register map, field positions and reset values of the CPU clock source control block
// Functional notes
// - Divider codes 0 to 4 give divide 1 to 16; low-speed source allows 1 or 2.
// - Shortest instruction lasts two CPU clock periods.
// - Power-up option, not a register, picks external or internal high-speed oscillator.
// - Reset clears the three mode registers; CPU starts on low-speed, both oscillators on.
// - Low-speed stop bit 0 runs the oscillator at 0 and stops it at 1.
// - Bits 1 to 7 of the low-speed mode register are read-only.
// - Low-speed oscillator starts after reset; stoppable only when the power-up option allows.
// - High-speed stop bit 7 stops the oscillator at 1; bits 0 to 6 read zero.
// - High-speed peripherals stall while stopped and need re-initialising afterwards.
// - Source-select bit 0 requests low-speed at 0 and high-speed at 1.
// - Status bit 1 is read-only and shows the source actually in use.
// - On the low-speed source the peripherals get a divided low-speed clock.
// - The stop-mode instruction halts the high-speed oscillator like the stop bit.
package clk_ctrl_pkg;

    localparam logic [15:0] ADDR_CPU_DIV     = 16'hfffb;
    localparam logic [15:0] ADDR_SRC_MODE    = 16'hffa1;
    localparam logic [15:0] ADDR_HS_OSC_CTRL = 16'hffa2;
    localparam logic [15:0] ADDR_LS_OSC_MODE = 16'hffa0;

    localparam logic [7:0]  RESET_CPU_DIV     = 8'h00;
    localparam logic [7:0]  RESET_SRC_MODE    = 8'h00;
    localparam logic [7:0]  RESET_HS_OSC_CTRL = 8'h00;
    localparam logic [7:0]  RESET_LS_OSC_MODE = 8'h00;

    localparam int DIV_CODE_LSB   = 0;
    localparam int DIV_CODE_W     = 3;
    localparam int LS_STOP_BIT    = 0;
    localparam int HS_STOP_BIT    = 7;
    localparam int SRC_SELECT_BIT = 0;
    localparam int SRC_STATUS_BIT = 1;

    localparam logic [2:0] DIV_CODE_MAX    = 3'h4;
    localparam logic [2:0] DIV_CODE_LS_MAX = 3'h1;

    localparam int INSTR_MIN_CLOCKS = 2;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_DRAIN,
        SW_ARM
    } switch_state_e;

endpackage

// ==== logic/cpu_clock_source_control.sv ====
// CPU clock source control: registers, oscillator enables, source switch and dividers
`timescale 1ns/1ps
module cpu_clock_source_control
    import clk_ctrl_pkg::*;
#(
    parameter int          DIV_W              = 4,
    parameter logic [2:0]  LS_PERIPH_DIV_LOG2 = 3'h1
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] addr,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    input  wire logic        opt_hs_internal,
    input  wire logic        opt_ls_stoppable,
    input  wire logic        stop_instr,
    input  wire logic        stop_wake,
    input  wire logic        hs_osc_tick,
    input  wire logic        ls_osc_tick,
    output logic             x1_osc_en,
    output logic             int_hs_osc_en,
    output logic             ls_osc_en,
    output logic             cpu_clk_tick,
    output logic             instr_slot_tick,
    output logic             periph_clk_tick,
    output logic             periph_on_ls,
    output logic             hs_periph_halted
);
    logic [2:0] div_code_q;
    logic       low_speed_stop_q;
    logic       high_speed_stop_q;
    logic       clock_source_select_q;
    logic       stop_mode_q;
    logic       opt_taken_q;
    logic       hs_internal_q;
    logic       ls_stoppable_q;
    logic       instr_phase_q;
    logic [7:0] rd_data_q;

    logic       wr_div;
    logic       wr_src;
    logic       wr_hs;
    logic       wr_ls;
    logic       hs_run;
    logic       clock_source_status;
    logic       main_tick;
    logic [2:0] div_eff;
    logic       ls_div_tick;
    logic [7:0] rd_mux;

    // Register write decode
    assign wr_div = wr_en && (addr == ADDR_CPU_DIV);
    assign wr_src = wr_en && (addr == ADDR_SRC_MODE);
    assign wr_hs  = wr_en && (addr == ADDR_HS_OSC_CTRL);
    assign wr_ls  = wr_en && (addr == ADDR_LS_OSC_MODE);

    // Software-writable controls; only the documented bits are stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_code_q            <= RESET_CPU_DIV[DIV_CODE_LSB +: DIV_CODE_W];
            low_speed_stop_q      <= RESET_LS_OSC_MODE[LS_STOP_BIT];
            high_speed_stop_q     <= RESET_HS_OSC_CTRL[HS_STOP_BIT];
            clock_source_select_q <= RESET_SRC_MODE[SRC_SELECT_BIT];
        end else begin
            if (wr_div) begin
                div_code_q <= wr_data[DIV_CODE_LSB +: DIV_CODE_W]; // Upper bits dropped
            end
            if (wr_ls) begin
                low_speed_stop_q <= wr_data[LS_STOP_BIT]; // Bits 1 to 7 ignored
            end
            if (wr_hs) begin
                high_speed_stop_q <= wr_data[HS_STOP_BIT];
            end
            if (wr_src) begin
                clock_source_select_q <= wr_data[SRC_SELECT_BIT]; // Status bit ignored
            end
        end
    end

    // Power-up options caught once, on the first edge after reset release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_taken_q    <= 1'b0;
            hs_internal_q  <= 1'b0;
            ls_stoppable_q <= 1'b0;
        end else if (!opt_taken_q) begin
            opt_taken_q    <= 1'b1;
            hs_internal_q  <= opt_hs_internal;
            ls_stoppable_q <= opt_ls_stoppable;
        end
    end

    // Stop mode holds until wake; a new stop request wins over a wake
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_mode_q <= 1'b0;
        end else if (stop_instr) begin
            stop_mode_q <= 1'b1;
        end else if (stop_wake) begin
            stop_mode_q <= 1'b0;
        end
    end

    // Oscillator enables; low-speed runs unless stopping is allowed and asked
    assign hs_run        = !high_speed_stop_q && !stop_mode_q;
    assign x1_osc_en     = hs_run && opt_taken_q && !hs_internal_q;
    assign int_hs_osc_en = hs_run && opt_taken_q && hs_internal_q;
    assign ls_osc_en     = !(low_speed_stop_q && ls_stoppable_q);

    // High-speed peripherals stall while their clock is stopped
    assign hs_periph_halted = !hs_run;

    source_switch u_switch (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .req_hs   (clock_source_select_q),
        .hs_avail (hs_run),
        .hs_tick  (hs_osc_tick && hs_run),
        .ls_tick  (ls_osc_tick && ls_osc_en),
        .sel_hs   (clock_source_status),
        .tick_out (main_tick)
    );

    // Divide code, clamped to the legal set for the active source
    assign div_eff = !clock_source_status ?
                     ((div_code_q > DIV_CODE_LS_MAX) ? DIV_CODE_LS_MAX : div_code_q) :
                     ((div_code_q > DIV_CODE_MAX) ? DIV_CODE_MAX : div_code_q);

    tick_divider #(
        .W (DIV_W)
    ) u_cpu_div (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .tick_in    (main_tick),
        .log2_ratio (div_eff),
        .tick_out   (cpu_clk_tick)
    );

    tick_divider #(
        .W (DIV_W)
    ) u_ls_periph_div (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .tick_in    (ls_osc_tick && ls_osc_en),
        .log2_ratio (LS_PERIPH_DIV_LOG2),
        .tick_out   (ls_div_tick)
    );

    // Peripheral clock follows the source actually in use
    assign periph_on_ls    = !clock_source_status;
    assign periph_clk_tick = clock_source_status ? (hs_osc_tick && hs_run) : ls_div_tick;

    // One instruction slot every second CPU clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_phase_q <= 1'b0;
        end else if (cpu_clk_tick) begin
            instr_phase_q <= !instr_phase_q;
        end
    end
    assign instr_slot_tick = cpu_clk_tick && instr_phase_q;

    // Read mux; reserved bits read as zero
    assign rd_mux = (addr == ADDR_CPU_DIV)     ? {5'h00, div_code_q} :
                    (addr == ADDR_LS_OSC_MODE) ? {7'h00, low_speed_stop_q} :
                    (addr == ADDR_HS_OSC_CTRL) ? {high_speed_stop_q, 7'h00} :
                    (addr == ADDR_SRC_MODE)    ?
                        {6'h00, clock_source_status, clock_source_select_q} :
                    8'h00;

    // Read data registered one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            rd_data_q <= rd_mux;
        end
    end
    assign rd_data = rd_data_q;
endmodule

// ==== logic/source_switch.sv ====
// Glitch-free selection between low-speed and high-speed tick streams
`timescale 1ns/1ps
module source_switch
    import clk_ctrl_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic req_hs,
    input  wire logic hs_avail,
    input  wire logic hs_tick,
    input  wire logic ls_tick,
    output logic      sel_hs,
    output logic      tick_out
);
    switch_state_e state_q;
    logic          sel_hs_q;
    logic          old_tick;
    logic          new_tick;
    logic          want_change;

    assign old_tick    = sel_hs_q ? hs_tick : ls_tick;
    assign new_tick    = sel_hs_q ? ls_tick : hs_tick;
    assign want_change = (req_hs != sel_hs_q) && (!req_hs || hs_avail);
    // No ticks pass while the switch is between sources
    assign tick_out    = (state_q == SW_RUN) && old_tick;
    assign sel_hs      = sel_hs_q;

    // Finish on an old-source edge, then start on a new-source edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= SW_RUN;
            sel_hs_q <= 1'b0;
        end else begin
            case (state_q)
                SW_RUN: begin
                    if (want_change) begin
                        state_q <= SW_DRAIN;
                    end
                end
                SW_DRAIN: begin
                    if (!want_change) begin
                        state_q <= SW_RUN; // Request withdrawn or target stopped
                    end else if (old_tick) begin
                        state_q <= SW_ARM;
                    end
                end
                SW_ARM: begin
                    // A target stopped mid-switch would never tick; fall back
                    if (!want_change) begin
                        state_q <= SW_RUN;
                    end else if (new_tick) begin
                        state_q  <= SW_RUN;
                        sel_hs_q <= !sel_hs_q;
                    end
                end
                default: begin
                    state_q <= SW_RUN;
                end
            endcase
        end
    end
endmodule

// ==== logic/tick_divider.sv ====
// Divides a stream of source ticks by a power of two
`timescale 1ns/1ps
module tick_divider
    import clk_ctrl_pkg::*;
#(
    parameter int W = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         tick_in,
    input  wire logic [2:0]   log2_ratio,
    output logic              tick_out
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] mask;

    // Ones in the low log2_ratio bits mark the wrap point
    assign mask     = W'((1 << log2_ratio) - 1);
    assign tick_out = tick_in && ((cnt_q & mask) == mask);

    // Free-running count of source ticks
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (tick_in) begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule

// ==== verification/clk_ctrl_sva.sv ====
// Assertion checker bound to the CPU clock source control block
`timescale 1ns/1ps
module clk_ctrl_sva
    import clk_ctrl_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [15:0] addr,
    input wire logic        rd_en,
    input wire logic [7:0]  rd_data,
    input wire logic        opt_hs_internal,
    input wire logic        opt_ls_stoppable,
    input wire logic        stop_instr,
    input wire logic        x1_osc_en,
    input wire logic        int_hs_osc_en,
    input wire logic        ls_osc_en,
    input wire logic        cpu_clk_tick,
    input wire logic        instr_slot_tick,
    input wire logic        hs_periph_halted
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Oscillator enables against options and stop controls
    ls_stop_gate_a: assert property ($fell(ls_osc_en) |-> opt_ls_stoppable)
        else $error("low-speed osc stopped while not permitted");
    hs_osc_pick_a: assert property (x1_osc_en |-> !opt_hs_internal && !int_hs_osc_en)
        else $error("wrong high-speed oscillator enabled");
    hs_halt_off_a: assert property (hs_periph_halted |-> !x1_osc_en && !int_hs_osc_en)
        else $error("high-speed osc runs while halted");
    stop_mode_a: assert property (stop_instr |=> hs_periph_halted [*2])
        else $error("stop instruction did not halt high-speed clock");
    // Read-as-zero bits of the three mode registers
    hs_rd_zero_a: assert property (rd_en && addr == ADDR_HS_OSC_CTRL |=> rd_data[6:0] == 7'h00)
        else $error("high-speed control low bits not zero");
    ls_rd_zero_a: assert property (rd_en && addr == ADDR_LS_OSC_MODE |=> rd_data[7:1] == 7'h00)
        else $error("low-speed mode upper bits not zero");
    src_rd_zero_a: assert property (rd_en && addr == ADDR_SRC_MODE |=> rd_data[7:2] == 6'h00)
        else $error("source mode upper bits not zero");
    // Instruction slot lands on a CPU tick and never twice running
    slot_on_tick_a: assert property (instr_slot_tick |-> cpu_clk_tick ##1 !instr_slot_tick)
        else $error("instruction slot without cpu tick");
    cover property (stop_instr);
    cover property ($fell(ls_osc_en));
    cover property (instr_slot_tick);
    cover property (int_hs_osc_en);
endmodule

bind cpu_clock_source_control clk_ctrl_sva clk_ctrl_sva_inst (
    .ref_clk, .rst_n, .addr, .rd_en, .rd_data, .opt_hs_internal, .opt_ls_stoppable,
    .stop_instr, .x1_osc_en, .int_hs_osc_en, .ls_osc_en, .cpu_clk_tick, .instr_slot_tick,
    .hs_periph_halted);

// ==== verification/cpu_clock_source_control_test.sv ====
// Self-checking testbench for the CPU clock source control block
`timescale 1ns/1ps
module cpu_clock_source_control_test;
    import clk_ctrl_pkg::*;
    typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] r;} row_s;
    logic        ref_clk, rst_n, wr_en, rd_en, stop_instr, stop_wake, hs_osc_tick;
    logic        ls_osc_tick, x1_osc_en, int_hs_osc_en, ls_osc_en, cpu_clk_tick;
    logic        instr_slot_tick, periph_on_ls, hs_periph_halted, periph_clk_tick;
    logic        opt_hs_internal, opt_ls_stoppable;
    logic [15:0] addr;
    logic [7:0]  wr_data, rd_data, got;
    int          failures, checks_done, cyc, n_src, n_cpu, n_ins, n_per;
    row_s        rows [7] = '{'{16'h1234, 8'hff, 8'h00}, '{ADDR_HS_OSC_CTRL, 8'hff, 8'h80},
        '{ADDR_HS_OSC_CTRL, 8'h00, 8'h00}, '{ADDR_LS_OSC_MODE, 8'hfe, 8'h00},
        '{ADDR_LS_OSC_MODE, 8'h00, 8'h00}, '{ADDR_CPU_DIV, 8'h03, 8'h03},
        '{ADDR_CPU_DIV, 8'h00, 8'h00}};

    cpu_clock_source_control cpu_clock_source_control_inst (
        .ref_clk, .rst_n, .addr, .wr_en, .rd_en, .wr_data, .rd_data,
        .opt_hs_internal, .opt_ls_stoppable, .stop_instr, .stop_wake,
        .hs_osc_tick, .ls_osc_tick, .x1_osc_en, .int_hs_osc_en, .ls_osc_en, .cpu_clk_tick,
        .instr_slot_tick, .periph_clk_tick, .periph_on_ls, .hs_periph_halted);

    initial begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Oscillator ticks only while enabled; cycle ceiling cuts a hang
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        hs_osc_tick <= #1 (x1_osc_en || int_hs_osc_en) && cyc[0];
        ls_osc_tick <= #1 ls_osc_en && cyc[2:0] == 3'h0;
        if (cyc == 10000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(string nm, logic [7:0] e, logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic near(string nm, int e, int s);
        checks_done++;
        if (s > e + 1 || s < e - 1) begin
            failures++;
            $display("unexpected %s: expected %0d seen %0d", nm, e, s);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge ref_clk) #1;
        addr = a;
        wr_data = d;
        wr_en = 1;
        @(posedge ref_clk) #1;
        wr_en = 0;
    endtask

    task automatic rd(logic [15:0] a);
        @(posedge ref_clk) #1;
        addr = a;
        rd_en = 1;
        @(posedge ref_clk) #1;
        rd_en = 0;
        got = rd_data;
    endtask

    // Poll the status bit under a bounded count
    task automatic wait_status(logic v);
        int n;
        n = 0;
        do begin
            rd(ADDR_SRC_MODE);
            n++;
        end while (got[SRC_STATUS_BIT] !== v && n < 60);
        check("status", {7'h0, v}, {7'h0, got[SRC_STATUS_BIT]});
    endtask

    // Count source, CPU and slot ticks over a fixed window
    task automatic count(logic on_hs, int sh);
        n_src = 0;
        n_cpu = 0;
        n_ins = 0;
        n_per = 0;
        repeat (320) begin
            @(posedge ref_clk) #2;
            n_src += on_hs ? hs_osc_tick : ls_osc_tick;
            n_cpu += cpu_clk_tick;
            n_ins += instr_slot_tick;
            n_per += periph_clk_tick;
        end
        near("cpu_ticks", n_src >> sh, n_cpu);
        near("slot_ticks", n_cpu >> 1, n_ins);
        near("periph_ticks", on_hs ? n_src : n_src >> 1, n_per);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {rst_n, wr_en, rd_en, stop_instr, stop_wake, hs_osc_tick, ls_osc_tick} = '0;
        opt_hs_internal = 1'b0;
        opt_ls_stoppable = 1'b1;
        {addr, wr_data, failures, checks_done, cyc} = '0;
        repeat (16) @(posedge ref_clk);
        #1 rst_n = 1;
        check("ls_en", 1, ls_osc_en);
        check("on_ls", 1, periph_on_ls);
        foreach (rows[i]) begin
            rd(rows[i].a);
            check("reset_value", 8'h00, got);
        end
        check("x1_en", 1, x1_osc_en);
        check("int_hs_en", 0, int_hs_osc_en);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            check("readback", rows[i].r, got);
        end
        // Move to high speed and walk every divider code
        wr(ADDR_SRC_MODE, 8'h01);
        wait_status(1);
        check("on_ls", 0, periph_on_ls);
        for (int c = 0; c < 5; c++) begin
            wr(ADDR_CPU_DIV, 8'(c));
            count(1, c);
        end
        wr(ADDR_LS_OSC_MODE, 8'h01);
        check("ls_en", 0, ls_osc_en);
        rd(ADDR_LS_OSC_MODE);
        check("ls_readback", 8'h01, got);
        wr(ADDR_LS_OSC_MODE, 8'h00);
        check("ls_en", 1, ls_osc_en);
        // Back to low speed; code 4 acts as divide by 2
        wr(ADDR_SRC_MODE, 8'h00);
        wait_status(0);
        count(0, 1);
        wr(ADDR_HS_OSC_CTRL, 8'h80);
        check("x1_en", 0, x1_osc_en);
        check("halted", 1, hs_periph_halted);
        wr(ADDR_SRC_MODE, 8'h01);
        repeat (40) @(posedge ref_clk);
        rd(ADDR_SRC_MODE);
        check("held_on_ls", 8'h01, got);
        wr(ADDR_HS_OSC_CTRL, 8'h00);
        wait_status(1);
        wr(ADDR_SRC_MODE, 8'h00);
        wait_status(0);
        // Stop mode and its release
        @(posedge ref_clk) #1 stop_instr = 1;
        @(posedge ref_clk) #1 stop_instr = 0;
        check("stop_halt", 1, hs_periph_halted);
        check("stop_x1", 0, x1_osc_en);
        @(posedge ref_clk) #1 stop_wake = 1;
        @(posedge ref_clk) #1 stop_wake = 0;
        check("wake", 0, hs_periph_halted);
        // Stop and wake in one cycle: stop must win
        @(posedge ref_clk) #1 {stop_instr, stop_wake} = 2'b11;
        @(posedge ref_clk) #1 {stop_instr, stop_wake} = 2'b00;
        check("stop_wins", 1, hs_periph_halted);
        @(posedge ref_clk) #1 stop_wake = 1;
        @(posedge ref_clk) #1 stop_wake = 0;
        check("wake_again", 0, hs_periph_halted);
        // Second reset with the other power-up options
        @(posedge ref_clk) #1 rst_n = 0;
        opt_hs_internal = 1'b1;
        opt_ls_stoppable = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1;
        check("rd_reset", 8'h00, rd_data);
        check("ls_en_reset", 1, ls_osc_en);
        rd(ADDR_SRC_MODE);
        check("src_reset", 8'h00, got);
        check("int_hs_en", 1, int_hs_osc_en);
        check("x1_off", 0, x1_osc_en);
        wr(ADDR_SRC_MODE, 8'h01);
        wait_status(1);
        count(1, 0);
        wr(ADDR_LS_OSC_MODE, 8'h01);
        check("ls_kept", 1, ls_osc_en);
        give_verdict();
    end
endmodule
